/* core/msou_top.sv */
// Executes bit operations, index modify and stack push/pop/flush instructions.
module msou_top
    import msou_pkg::*;
#(
    parameter int unsigned LOOP_DEPTH = 6,
    parameter int unsigned STS_DEPTH = 15,
    parameter int unsigned PC_DEPTH = 30
) (
    input wire logic mclk_i,
    input wire logic rstn_i,
    input wire logic insn_valid_i,
    input wire logic [MSOU_INSN_W-1:0] insn_i,
    input wire logic dual_mode_i,
    input wire logic circular_buffer_enable_i,
    input wire logic loop_address_wr_i,
    input wire logic [MSOU_WORD_W-1:0] loop_address_wdata_i,
    input wire logic [MSOU_NUM_IREG*MSOU_WORD_W-1:0] len_regs_i,
    input wire logic [MSOU_NUM_IREG*MSOU_WORD_W-1:0] base_regs_i,
    input wire logic [MSOU_SREG_W-1:0] sreg_rd_sel_i,
    output logic [MSOU_WORD_W-1:0] sreg_rd_data_o,
    output logic [MSOU_WORD_W-1:0] arith_status_x_o,
    output logic [MSOU_WORD_W-1:0] arith_status_y_o,
    output logic [MSOU_WORD_W-1:0] ireg_rd_data_o,
    output logic [MSOU_WORD_W-1:0] loop_address_top_o,
    output logic loop_stack_push_o,
    output logic loop_stack_pop_o,
    output logic status_stack_push_o,
    output logic status_stack_pop_o,
    output logic pc_stack_push_o,
    output logic pc_stack_pop_o,
    output logic cache_flush_o,
    output logic mem_addr_valid_o,
    output logic [2:0] loop_ptr_o,
    output logic [3:0] status_ptr_o,
    output logic [4:0] pc_ptr_o
);
    // Only the arithmetic status register has a Y-element copy; no other register is duplicated.
    function automatic logic has_complement(input logic [MSOU_SREG_W-1:0] sel);
        return (sel == MSOU_SREG_ASTAT);
    endfunction

    function automatic logic [MSOU_WORD_W-1:0] bit_op(
        input logic [2:0] op, input logic [MSOU_WORD_W-1:0] r,
        input logic [MSOU_WORD_W-1:0] d);
        logic [MSOU_WORD_W-1:0] res;
        res = r;
        unique case (op)
            MSOU_BOP_SET: res = r | d;
            MSOU_BOP_CLR: res = r & ~d;
            MSOU_BOP_TGL: res = r ^ d;
            default: res = r;
        endcase
        return res;
    endfunction

    function automatic logic bit_test(
        input logic [2:0] op, input logic [MSOU_WORD_W-1:0] r,
        input logic [MSOU_WORD_W-1:0] d);
        return (op == MSOU_BOP_TST) ? ((r & d) == d) : (r == d);
    endfunction

    // Instruction fields.
    logic [7:0] opc;
    logic [2:0] bit_op_select;
    logic [MSOU_SREG_W-1:0] sel;
    logic [MSOU_WORD_W-1:0] imm;
    logic [MSOU_IDX_W-1:0] iidx;
    logic is_bitop, is_mod, is_rev, is_stk, bop_ok, is_test, y_on;
    always_comb begin
        opc = insn_i[MSOU_OPC_HI:MSOU_OPC_LO];
        bit_op_select = insn_i[MSOU_BOP_HI:MSOU_BOP_LO];
        sel = insn_i[MSOU_SREG_HI:MSOU_SREG_LO];
        imm = {insn_i[MSOU_DATA_HI_HI:MSOU_DATA_HI_LO], insn_i[MSOU_DATA_LO_HI:0]};
        iidx = {insn_i[MSOU_GSEL_BIT], insn_i[MSOU_ISEL_HI:MSOU_ISEL_LO]};
        is_bitop = insn_valid_i && (opc == MSOU_OPC_BITOP);
        is_mod = insn_valid_i && (opc == MSOU_OPC_MODIFY || opc == MSOU_OPC_BIT_REVERSE_MODIFY);
        is_rev = (opc == MSOU_OPC_BIT_REVERSE_MODIFY);
        is_stk = insn_valid_i && (opc == MSOU_OPC_STACK);
        bop_ok = (bit_op_select inside {MSOU_BOP_SET, MSOU_BOP_CLR, MSOU_BOP_TGL,
                              MSOU_BOP_TST, MSOU_BOP_XOR});
        is_test = (bit_op_select == MSOU_BOP_TST) || (bit_op_select == MSOU_BOP_XOR);
        y_on = dual_mode_i && has_complement(sel);
    end

    // System register file for the X element only; arithmetic status of both elements kept apart.
    logic [MSOU_NUM_SREG*MSOU_WORD_W-1:0] xflat, yflat;
    logic [MSOU_WORD_W-1:0] xr, yr, next_x, next_y, yrd_unused;
    logic xwe, ywe, next_flag_x, next_flag_y;
    logic [MSOU_WORD_W-1:0] astat_x, astat_y, next_astat_x, next_astat_y;
    logic [MSOU_SREG_W-1:0] xwaddr;
    logic [MSOU_WORD_W-1:0] xwdata;

    always_comb begin
        xr = (sel == MSOU_SREG_ASTAT) ? astat_x : xflat[sel*MSOU_WORD_W +: MSOU_WORD_W];
        yr = astat_y;
        next_x = bit_op(bit_op_select, xr, imm);
        next_y = bit_op(bit_op_select, yr, imm);
        next_flag_x = bit_test(bit_op_select, xr, imm);
        next_flag_y = bit_test(bit_op_select, yr, imm);
        xwe = is_bitop && bop_ok;
        ywe = 1'b0;
        next_astat_x = astat_x;
        next_astat_y = astat_y;
        if (is_bitop && bop_ok) begin
            if (is_test) begin
                next_astat_x[MSOU_BTF_BIT] = next_flag_x;
                if (y_on) begin
                    next_astat_y[MSOU_BTF_BIT] = next_flag_y;
                end
            end else if (sel == MSOU_SREG_ASTAT) begin
                next_astat_x = next_x;
                if (y_on) begin
                    next_astat_y = next_y;
                end
            end
        end
        // The status copy in the file is kept in step so a read of it shows the flag.
        xwaddr = is_test ? MSOU_SREG_ASTAT : sel;
        xwdata = (xwaddr == MSOU_SREG_ASTAT) ? next_astat_x : next_x;
    end

    always_ff @(posedge mclk_i) begin
        if (!rstn_i) begin
            astat_x <= MSOU_SREG_RST;
            astat_y <= MSOU_SREG_RST;
        end else begin
            astat_x <= next_astat_x;
            astat_y <= next_astat_y;
        end
    end

    msou_sreg_file #(.WIDTH(MSOU_WORD_W), .DEPTH(MSOU_NUM_SREG), .AW(MSOU_SREG_W)) u_xregs (
        .mclk_i(mclk_i),
        .rstn_i(rstn_i),
        .we_i(xwe),
        .waddr_i(xwaddr),
        .wdata_i(xwdata),
        .raddr_i(sreg_rd_sel_i),
        .rdata_o(sreg_rd_data_o),
        .flat_o(xflat)
    );
    assign yflat = '0;
    assign yrd_unused = '0;

    // Index registers with circular wrap and bit reverse.
    logic [MSOU_WORD_W-1:0] ireg [MSOU_NUM_IREG];
    logic [MSOU_WORD_W-1:0] icur, ilen, ibase, isum, iwrap, inew;
    always_comb begin
        icur = ireg[iidx];
        ilen = len_regs_i[iidx*MSOU_WORD_W +: MSOU_WORD_W];
        ibase = base_regs_i[iidx*MSOU_WORD_W +: MSOU_WORD_W];
        isum = icur + imm;
        iwrap = isum;
        // Wrap ignores the enable bit; a nonzero length alone defines the buffer.
        if (ilen != '0) begin
            if (isum >= ibase + ilen) begin
                iwrap = isum - ilen;
            end else if (isum < ibase) begin
                iwrap = isum + ilen;
            end
        end
        inew = is_rev ? {<<{iwrap}} : iwrap;
    end

    for (genvar g = 0; g < MSOU_NUM_IREG; g++) begin : g_ireg
        always_ff @(posedge mclk_i) begin
            if (!rstn_i) begin
                ireg[g] <= '0;
            end else if (is_mod && (iidx == MSOU_IDX_W'(g))) begin
                ireg[g] <= inew;
            end
        end
    end

    // Stack controls decoded from seven independent bits.
    logic loop_stack_push, loop_stack_pop, status_stack_push, status_stack_pop, pc_stack_push, pc_stack_pop, fcb;
    always_comb begin
        loop_stack_push = is_stk && insn_i[MSOU_LPU_BIT];
        loop_stack_pop = is_stk && insn_i[MSOU_LPO_BIT];
        status_stack_push = is_stk && insn_i[MSOU_SPU_BIT];
        status_stack_pop = is_stk && insn_i[MSOU_SPO_BIT];
        pc_stack_push = is_stk && insn_i[MSOU_PPU_BIT];
        pc_stack_pop = is_stk && insn_i[MSOU_PPO_BIT];
        fcb = is_stk && insn_i[MSOU_FC_BIT];
    end

    // All three stacks step in the same cycle, each with its own pointer.
    logic [2:0] lptr;
    logic [3:0] sptr;
    logic [4:0] pptr;
    msou_stack_ctl #(.DEPTH(LOOP_DEPTH), .PW(3)) u_loop (
        .mclk_i(mclk_i), .rstn_i(rstn_i), .push_i(loop_stack_push), .pop_i(loop_stack_pop),
        .ptr_o(lptr), .empty_o(), .full_o());
    msou_stack_ctl #(.DEPTH(STS_DEPTH), .PW(4)) u_sts (
        .mclk_i(mclk_i), .rstn_i(rstn_i), .push_i(status_stack_push), .pop_i(status_stack_pop),
        .ptr_o(sptr), .empty_o(), .full_o());
    msou_stack_ctl #(.DEPTH(PC_DEPTH), .PW(5)) u_pc (
        .mclk_i(mclk_i), .rstn_i(rstn_i), .push_i(pc_stack_push), .pop_i(pc_stack_pop),
        .ptr_o(pptr), .empty_o(), .full_o());

    // Loop address entries are kept so a pop shows the entry beneath again.
    logic [MSOU_WORD_W-1:0] lstk [LOOP_DEPTH];
    logic [MSOU_WORD_W-1:0] next_ltop, lwdata;
    logic [2:0] lwaddr, lkeep;
    logic lwe;
    always_comb begin
        next_ltop = loop_address_top_o;
        lwe = 1'b0;
        lwaddr = lptr;
        lwdata = '0;
        lkeep = lptr;
        if (loop_stack_pop && !loop_stack_push && (lptr != 3'h0)) begin
            lkeep = lptr - 3'h1;
            next_ltop = (lkeep != 3'h0) ? lstk[lkeep - 3'h1] : '0;
        end
        if (loop_address_wr_i && !loop_stack_push && (lkeep != 3'h0)) begin
            lwe = 1'b1;
            lwaddr = lkeep - 3'h1;
            lwdata = loop_address_wdata_i;
            next_ltop = loop_address_wdata_i;
        end
        if (loop_stack_push) begin
            next_ltop = '0;
            lwe = (lptr != 3'(LOOP_DEPTH));
            lwaddr = lptr;
            lwdata = '0;
        end
    end

    for (genvar g = 0; g < LOOP_DEPTH; g++) begin : g_lstk
        always_ff @(posedge mclk_i) begin
            if (!rstn_i) begin
                lstk[g] <= '0;
            end else if (lwe && (lwaddr == 3'(g))) begin
                lstk[g] <= lwdata;
            end
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!rstn_i) begin
            loop_address_top_o <= '0;
            {loop_stack_push_o, loop_stack_pop_o, status_stack_push_o} <= 3'h0;
            {status_stack_pop_o, pc_stack_push_o, pc_stack_pop_o} <= 3'h0;
            cache_flush_o <= 1'b0;
            mem_addr_valid_o <= 1'b0;
            ireg_rd_data_o <= '0;
            arith_status_x_o <= MSOU_SREG_RST;
            arith_status_y_o <= MSOU_SREG_RST;
            loop_ptr_o <= '0;
            status_ptr_o <= '0;
            pc_ptr_o <= '0;
        end else begin
            loop_address_top_o <= next_ltop;
            {loop_stack_push_o, loop_stack_pop_o, status_stack_push_o} <= {loop_stack_push, loop_stack_pop, status_stack_push};
            {status_stack_pop_o, pc_stack_push_o, pc_stack_pop_o} <= {status_stack_pop, pc_stack_push, pc_stack_pop};
            cache_flush_o <= fcb;
            mem_addr_valid_o <= 1'b0;
            ireg_rd_data_o <= is_mod ? inew : ireg[iidx];
            arith_status_x_o <= next_astat_x;
            arith_status_y_o <= next_astat_y;
            loop_ptr_o <= lptr;
            status_ptr_o <= sptr;
            pc_ptr_o <= pptr;
        end
    end

    // Assertions.
    a_set_forces_ones: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        is_bitop && bit_op_select == MSOU_BOP_SET && sel == MSOU_SREG_ASTAT
        |=> ((arith_status_x_o & $past(imm)) == $past(imm)))
        else $error("Set left a mask bit low.");
    a_clr_forces_zero: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        is_bitop && bit_op_select == MSOU_BOP_CLR && sel == MSOU_SREG_ASTAT
        |=> ((arith_status_x_o & $past(imm)) == '0))
        else $error("Clear left a mask bit high.");
    a_tgl_inverts: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        is_bitop && bit_op_select == MSOU_BOP_TGL && sel == MSOU_SREG_ASTAT
        |=> (arith_status_x_o == ($past(astat_x) ^ $past(imm))))
        else $error("Toggle result wrong.");
    a_test_flag: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        is_bitop && bit_op_select == MSOU_BOP_TST
        |=> arith_status_x_o[MSOU_BTF_BIT] == $past(((xr & imm) == imm)))
        else $error("Test flag wrong.");
    a_cmp_flag: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        is_bitop && bit_op_select == MSOU_BOP_XOR
        |=> arith_status_x_o[MSOU_BTF_BIT] == $past(xr == imm))
        else $error("Compare flag wrong.");
    a_y_only_dual: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        is_bitop && !y_on |=> $stable(arith_status_y_o))
        else $error("Y register changed outside dual mode.");
    a_no_mem_addr: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        is_mod |-> ##1 !mem_addr_valid_o [*2])
        else $error("Modify drove an address.");
    a_flush_pulse: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        fcb |=> cache_flush_o)
        else $error("Flush not issued in time.");
    a_loop_zero: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        loop_stack_push |=> loop_address_top_o == '0)
        else $error("Loop top not cleared on push.");
    a_reserved_op: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        is_bitop && !bop_ok |=> $stable(arith_status_x_o) && $stable(arith_status_y_o))
        else $error("Reserved operation changed state.");
endmodule

/* core/msou_pkg.sv */
// Shared constants for the miscellaneous system-operation unit.
package msou_pkg;
    localparam int unsigned MSOU_WORD_W = 32;
    localparam int unsigned MSOU_INSN_W = 48;
    localparam int unsigned MSOU_SREG_W = 4;
    localparam int unsigned MSOU_NUM_SREG = 16;
    localparam int unsigned MSOU_NUM_IREG = 16;
    localparam int unsigned MSOU_IDX_W = 4;
    // Major opcode fields, bits 47..40.
    localparam int unsigned MSOU_OPC_HI = 47;
    localparam int unsigned MSOU_OPC_LO = 40;
    localparam logic [7:0] MSOU_OPC_BITOP = 8'h14;
    localparam logic [7:0] MSOU_OPC_STACK = 8'h17;
    localparam logic [7:0] MSOU_OPC_MODIFY = 8'h16;
    localparam logic [7:0] MSOU_OPC_BIT_REVERSE_MODIFY = 8'h06;
    // Bit-operation fields.
    localparam int unsigned MSOU_BOP_HI = 39;
    localparam int unsigned MSOU_BOP_LO = 37;
    localparam int unsigned MSOU_SREG_HI = 36;
    localparam int unsigned MSOU_SREG_LO = 33;
    localparam int unsigned MSOU_DATA_HI_HI = 31;
    localparam int unsigned MSOU_DATA_HI_LO = 24;
    localparam int unsigned MSOU_DATA_LO_HI = 23;
    // Modify fields.
    localparam int unsigned MSOU_GSEL_BIT = 38;
    localparam int unsigned MSOU_ISEL_HI = 34;
    localparam int unsigned MSOU_ISEL_LO = 32;
    // Stack control bit positions.
    localparam int unsigned MSOU_LPU_BIT = 39;
    localparam int unsigned MSOU_LPO_BIT = 38;
    localparam int unsigned MSOU_SPU_BIT = 37;
    localparam int unsigned MSOU_SPO_BIT = 36;
    localparam int unsigned MSOU_PPU_BIT = 35;
    localparam int unsigned MSOU_PPO_BIT = 34;
    localparam int unsigned MSOU_FC_BIT = 33;
    // Arithmetic status register index and its flag position.
    localparam logic [3:0] MSOU_SREG_ASTAT = 4'h4;
    localparam int unsigned MSOU_BTF_BIT = 18;
    localparam logic [31:0] MSOU_SREG_RST = 32'h0000_0000;
    typedef enum logic [2:0] {
        MSOU_BOP_SET = 3'h0,
        MSOU_BOP_CLR = 3'h1,
        MSOU_BOP_TGL = 3'h2,
        MSOU_BOP_TST = 3'h4,
        MSOU_BOP_XOR = 3'h5
    } msou_bop_e;
endpackage

/* core/msou_sreg_file.sv */
// Small register memory with registered read data, used for the system registers.
module msou_sreg_file
    import msou_pkg::*;
#(
    parameter int unsigned WIDTH = 32,
    parameter int unsigned DEPTH = 16,
    parameter int unsigned AW = 4
) (
    input wire logic mclk_i,
    input wire logic rstn_i,
    input wire logic we_i,
    input wire logic [AW-1:0] waddr_i,
    input wire logic [WIDTH-1:0] wdata_i,
    input wire logic [AW-1:0] raddr_i,
    output logic [WIDTH-1:0] rdata_o,
    output logic [WIDTH*DEPTH-1:0] flat_o
);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [WIDTH-1:0] next_rdata;

    always_comb begin
        next_rdata = mem[raddr_i];
        if (we_i && (waddr_i == raddr_i)) begin
            next_rdata = wdata_i;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!rstn_i) begin
            rdata_o <= '0;
        end else begin
            rdata_o <= next_rdata;
        end
    end

    for (genvar g = 0; g < DEPTH; g++) begin : g_word
        always_ff @(posedge mclk_i) begin
            if (!rstn_i) begin
                mem[g] <= MSOU_SREG_RST;
            end else if (we_i && (waddr_i == AW'(g))) begin
                mem[g] <= wdata_i;
            end
        end
        assign flat_o[g*WIDTH +: WIDTH] = mem[g];
    end
endmodule

/* core/msou_stack_ctl.sv */
// Push and pop pointer for one hardware stack.
module msou_stack_ctl #(
    parameter int unsigned DEPTH = 6,
    parameter int unsigned PW = 3
) (
    input wire logic mclk_i,
    input wire logic rstn_i,
    input wire logic push_i,
    input wire logic pop_i,
    output logic [PW-1:0] ptr_o,
    output logic empty_o,
    output logic full_o
);
    logic [PW-1:0] ptr;
    logic [PW-1:0] next_ptr;

    // Each stack moves on its own; a push and pop together leave it still.
    always_comb begin
        next_ptr = ptr;
        if (push_i && !pop_i && (ptr != PW'(DEPTH))) begin
            next_ptr = ptr + PW'(1);
        end else if (pop_i && !push_i && (ptr != '0)) begin
            next_ptr = ptr - PW'(1);
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!rstn_i) begin
            ptr <= '0;
        end else begin
            ptr <= next_ptr;
        end
    end

    assign ptr_o = ptr;
    assign empty_o = (ptr == '0);
    assign full_o = (ptr == PW'(DEPTH));
endmodule

/* sim/msou_fetch_model.sv */
// Fetch and decode model that hands one instruction word per cycle to the unit.
module msou_fetch_model
    import msou_pkg::*;
(
    input wire logic mclk_i,
    output logic insn_valid_o,
    output logic [MSOU_INSN_W-1:0] insn_o
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        insn_valid_o = 1'b0;
        insn_o = '0;
    end
    // The word is driven off the falling edge so the unit samples a settled value.
    task automatic issue(input logic [MSOU_INSN_W-1:0] word);
        logic [MSOU_INSN_W-1:0] w;
        w = word;
        // A stack word that pushes never also pops; the pops are dropped.
        if (w[47:40] == MSOU_OPC_STACK && |{w[39], w[37], w[35]}) begin
            w = w & ~48'h0054_0000_0000;
        end
        @(negedge mclk_i);
        insn_valid_o = 1'b1;
        insn_o = w;
    endtask
    // An idle slot keeps the word lines moving so stale bits are never mistaken for data.
    task automatic idle();
        @(negedge mclk_i);
        insn_valid_o = 1'b0;
        insn_o = ~insn_o;
    endtask
endmodule

/* sim/msou_top_tb.sv */
// Self-checking bench for the miscellaneous system-operation unit.
module msou_top_tb;
    import msou_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int LD = 6;
    localparam int SD = 15;
    localparam int PD = 30;
    logic mclk_i = 1'b0;
    logic rstn_i = 1'b0;
    logic insn_valid;
    logic [47:0] insn;
    logic dual_mode = 1'b0;
    logic cbe = 1'b0;
    logic lw = 1'b0;
    logic [31:0] lwd = 32'h0000_0000;
    logic [511:0] len_regs = '0;
    logic [511:0] base_regs = '0;
    logic [3:0] sel = 4'h0;
    logic [31:0] sreg_rd, ast_x, ast_y, ireg_rd, ltop;
    logic loop_stack_push, loop_stack_pop, status_stack_push, status_stack_pop, pc_stack_push, pc_stack_pop, fc, mav;
    logic [2:0] lptr;
    logic [3:0] sptr;
    logic [4:0] pptr;
    logic [31:0] sr[16];
    logic [31:0] ir[16];
    logic [31:0] ay;
    logic [31:0] lq[$];
    int sp, pp, mi, n_mismatch, cmp_count, cycles;
    bit chk_top;
    msou_top #(.LOOP_DEPTH(LD), .STS_DEPTH(SD), .PC_DEPTH(PD)) u_dut (.mclk_i(mclk_i),
        .rstn_i(rstn_i), .insn_valid_i(insn_valid), .insn_i(insn), .dual_mode_i(dual_mode),
        .circular_buffer_enable_i(cbe), .loop_address_wr_i(lw), .loop_address_wdata_i(lwd),
        .len_regs_i(len_regs), .base_regs_i(base_regs), .sreg_rd_sel_i(sel),
        .sreg_rd_data_o(sreg_rd), .arith_status_x_o(ast_x), .arith_status_y_o(ast_y),
        .ireg_rd_data_o(ireg_rd), .loop_address_top_o(ltop), .loop_stack_push_o(loop_stack_push),
        .loop_stack_pop_o(loop_stack_pop), .status_stack_push_o(status_stack_push), .status_stack_pop_o(status_stack_pop),
        .pc_stack_push_o(pc_stack_push), .pc_stack_pop_o(pc_stack_pop), .cache_flush_o(fc),
        .mem_addr_valid_o(mav), .loop_ptr_o(lptr), .status_ptr_o(sptr), .pc_ptr_o(pptr));
    msou_fetch_model u_fm (.mclk_i(mclk_i), .insn_valid_o(insn_valid), .insn_o(insn));
    initial begin
        forever #5 mclk_i = ~mclk_i;
    end
    function automatic logic [31:0] bit_op_select(input logic [2:0] op, input logic [31:0] r,
            input logic [31:0] d, inout logic [31:0] st);
        case (op)
            3'h0: return r | d;
            3'h1: return r & ~d;
            3'h2: return r ^ d;
            3'h4: st[MSOU_BTF_BIT] = ((r & d) == d);
            3'h5: st[MSOU_BTF_BIT] = (r == d);
            default: ;
        endcase
        return r;
    endfunction
    function automatic logic [47:0] bw(input logic [2:0] op, input logic [3:0] s,
            input logic [31:0] d);
        return {MSOU_OPC_BITOP, op, s, 1'b0, d};
    endfunction
    function automatic logic [47:0] mw(input logic [7:0] opc, input logic g,
            input logic [2:0] i, input logic [31:0] d);
        return {opc, 1'b0, g, 3'h0, i, d};
    endfunction
    function automatic logic [47:0] sw(input logic [6:0] b);
        return {MSOU_OPC_STACK, b, 33'h0};
    endfunction
    task automatic model(input logic [47:0] m, input logic dm, input logic wr,
            input logic [31:0] wd);
        logic [31:0] t, n, s;
        logic f, stk;
        int k;
        f = m[39:37] inside {3'h4, 3'h5};
        stk = m[47:40] == MSOU_OPC_STACK;
        mi = -1;
        if (m[47:40] == MSOU_OPC_BITOP) begin
            k = m[36:33];
            t = sr[4];
            n = bit_op_select(m[39:37], sr[k], m[31:0], t);
            sr[k] = n;
            sr[4] = f ? t : sr[4];
            if (dm && k == 4) begin
                t = ay;
                n = bit_op_select(m[39:37], ay, m[31:0], t);
                ay = f ? t : n;
            end
        end else if (m[47:40] inside {MSOU_OPC_MODIFY, MSOU_OPC_BIT_REVERSE_MODIFY}) begin
            k = {m[38], m[34:32]};
            s = ir[k] + m[31:0];
            t = len_regs[k*32+:32];
            n = base_regs[k*32+:32];
            if (t != 0 && s >= n + t) s = s - t;
            else if (t != 0 && s < n) s = s + t;
            if (m[47:40] == MSOU_OPC_BIT_REVERSE_MODIFY) s = {<<{s}};
            ir[k] = s;
            mi = k;
        end else if (stk) begin
            if (m[39] && lq.size() < LD) lq.push_back(32'h0000_0000);
            if (m[38] && lq.size() > 0) void'(lq.pop_back());
            if (m[37] && sp < SD) sp++;
            if (m[36] && sp > 0) sp--;
            if (m[35] && pp < PD) pp++;
            if (m[34] && pp > 0) pp--;
        end
        if (wr && !(stk && m[39]) && lq.size() > 0) lq[$] = wd;
    endtask
    task automatic check_word(input string what, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic check_bit(input string what, input logic exp, input logic got);
        cmp_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected %s expected %b seen %b", what, exp, got);
        end
    endtask
    task automatic exec(input logic [47:0] w, input logic dm, input logic wr);
        logic [47:0] m;
        logic [6:0] st;
        u_fm.issue(w);
        m = insn;
        dual_mode = dm;
        cbe = 1'($urandom);
        lw = wr;
        lwd = $urandom;
        sel = w[36:33];
        model(m, dm, wr, lwd);
        u_fm.idle();
        lw = 1'b0;
        st = (m[47:40] == MSOU_OPC_STACK) ? m[39:33] : 7'h00;
        check_word("stack pulses", {25'h0, st}, {25'h0, loop_stack_push, loop_stack_pop, status_stack_push, status_stack_pop, pc_stack_push, pc_stack_pop, fc});
        check_bit("address out", 1'b0, mav);
        if (mi >= 0) check_word("index", ir[mi], ireg_rd);
        u_fm.idle();
        check_word("sreg read", sr[sel], sreg_rd);
        check_word("status x", sr[4], ast_x);
        check_word("status y", ay, ast_y);
        check_word("loop depth", lq.size(), {29'h0, lptr});
        check_word("status depth", sp, {28'h0, sptr});
        check_word("pc depth", pp, {27'h0, pptr});
        if (chk_top) check_word("loop top", lq.size() ? lq[$] : 32'h0, ltop);
    endtask
    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // A hung handshake would otherwise stall the run for ever.
    always @(posedge mclk_i) begin
        cycles++;
        if (cycles == 20000) begin
            n_mismatch++;
            finish_test();
        end
    end
    initial begin
        logic [47:0] w;
        logic [31:0] d;
        logic [3:0] k;
        void'($urandom(40));
        foreach (sr[i]) sr[i] = 32'h0000_0000;
        foreach (ir[i]) ir[i] = 32'h0000_0000;
        ay = 32'h0000_0000;
        len_regs[3*32+:32] = 32'h0000_0010;
        base_regs[3*32+:32] = 32'h0000_0100;
        repeat (20) @(negedge mclk_i);
        rstn_i = 1'b1;
        for (int op = 0; op < 8; op++) exec(bw(3'(op), 4'h2, 32'h0000_0070), 1'(op), 1'b0);
        exec(bw(3'h0, 4'h4, 32'h0000_0003), 1'b1, 1'b0);
        exec(bw(3'h4, 4'h4, 32'h0000_0001), 1'b1, 1'b0);
        $display("test bit operations done");
        exec(mw(MSOU_OPC_MODIFY, 1'b0, 3'h3, 32'h0000_0105), 1'b0, 1'b0);
        exec(mw(MSOU_OPC_MODIFY, 1'b0, 3'h3, 32'h0000_0010), 1'b0, 1'b0);
        exec(mw(MSOU_OPC_MODIFY, 1'b0, 3'h3, 32'hffff_fff0), 1'b1, 1'b0);
        exec(mw(MSOU_OPC_BIT_REVERSE_MODIFY, 1'b1, 3'h5, 32'h0000_0301), 1'b0, 1'b0);
        $display("test index modify done");
        chk_top = 1'b1;
        exec(sw(7'h40), 1'b0, 1'b1);
        exec(bw(3'h3, 4'h0, 32'h0000_0000), 1'b0, 1'b1);
        exec(sw(7'h40), 1'b0, 1'b0);
        exec(sw(7'h20), 1'b0, 1'b0);
        chk_top = 1'b0;
        exec(sw(7'h7f), 1'b0, 1'b0);
        repeat (32) exec(sw(7'h55), 1'b0, 1'($urandom));
        repeat (32) exec(sw(7'h2b), 1'b0, 1'b0);
        $display("test stacks done");
        repeat (300) begin
            d = $urandom;
            k = 4'($urandom);
            if ($urandom_range(1)) d = sr[k];
            case ($urandom_range(4))
                0: w = bw(3'($urandom), k, d);
                1: w = mw(MSOU_OPC_MODIFY, k[3], k[2:0], d);
                2: w = mw(MSOU_OPC_BIT_REVERSE_MODIFY, 1'b1, k[2:0], d);
                3: w = sw(7'($urandom));
                default: w = {8'h00, 8'($urandom), d};
            endcase
            exec(w, 1'($urandom), 1'($urandom));
        end
        $display("test random mix done");
        finish_test();
    end
endmodule
